// File: msc_pkg.sv
// Shared constants, types and helpers of the multibuffer serial controller.
// Assumes a single synchronous clock domain and no register bus.
package msc_pkg;

    localparam int          RAM_DEPTH        = 256;
    localparam int          WORD_W           = 16;
    localparam int          IDX_W            = 8;
    localparam int          CNT_W            = 10;

    // Field select codes of the software memory port
    localparam logic [1:0]  FIELD_TX         = 2'h0;
    localparam logic [1:0]  FIELD_RX         = 2'h1;
    localparam logic [1:0]  FIELD_CTL        = 2'h2;
    localparam logic [1:0]  FIELD_STAT       = 2'h3;

    // Control word layout: bits [3:0] hold word length minus one
    localparam int          CTL_LEN_LSB      = 0;
    localparam int          CTL_LEN_W        = 4;
    localparam logic [4:0]  LEN_MIN          = 5'h02;

    // Status word layout
    localparam int          STAT_DONE_BIT    = 0;
    localparam int          STAT_OVERRUN_BIT = 1;

    // Setup and hold cycle offsets
    localparam logic [CNT_W-1:0] SETUP_BASE      = 10'h002;
    localparam logic [CNT_W-1:0] SETUP_HOLD_BASE = 10'h003;
    localparam logic [CNT_W-1:0] RELEASE_BASE    = 10'h001;

    // Reset values
    localparam logic [WORD_W-1:0] WORD_RESET     = 16'h0000;
    localparam logic [IDX_W-1:0]  IDX_RESET      = 8'h00;
    localparam logic [CNT_W-1:0]  CNT_RESET      = 10'h000;
    localparam logic [4:0]        BITS_RESET     = 5'h00;

    // Gray-coded states along the transfer path
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_SETUP = 3'h1,
        ST_SHIFT = 3'h3,
        ST_HOLD  = 3'h2,
        ST_WRBK  = 3'h6
    } msc_state_type;

    typedef struct packed {
        msc_state_type     state;
        logic [IDX_W-1:0]  idx;
        logic [IDX_W-1:0]  last_idx;
        logic [CNT_W-1:0]  cnt;
        logic [4:0]        bits_left;
        logic [WORD_W-1:0] sh_tx;
        logic [WORD_W-1:0] sh_rx;
        logic              sclk;
        logic              cs_n;
        logic              mosi;
        logic              drive;
        logic              busy;
        logic              done;
        logic [WORD_W-1:0] rdata;
    } msc_ctrl_type;

    // Serial clock period in peripheral clock cycles
    function automatic logic [CNT_W-1:0] period_cycles(input logic [7:0] prescale);
        logic [CNT_W-1:0] p;
        p = {2'h0, prescale} + 10'h001;
        if (prescale == 8'h00) begin
            p = 10'h002;
        end
        return p;
    endfunction : period_cycles

endpackage : msc_pkg

// File: msc_baud.sv
// Baud generator: pulses at each serial clock edge while running.
// Assumes the controller loads the phase on the cycle of the first edge.
`timescale 1ns/1ps
module msc_baud (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    // Control
    input  wire logic       run,
    input  wire logic       load_phase,
    input  wire logic [7:0] prescale,
    // Edge request
    output logic            edge_pulse
);

    logic [msc_pkg::CNT_W-1:0] cnt_reg;
    logic [msc_pkg::CNT_W-1:0] cnt_next;
    logic [msc_pkg::CNT_W-1:0] period;
    logic [msc_pkg::CNT_W-1:0] half;

    always_comb begin
        period     = msc_pkg::period_cycles(prescale);
        half       = period >> 1;
        edge_pulse = run && ((cnt_reg == half - 10'h001) || (cnt_reg == period - 10'h001));
        cnt_next   = cnt_reg;
        if (load_phase) begin
            // First edge already issued: next one ends the first half
            cnt_next = half;
        end else if (run) begin
            cnt_next = (cnt_reg == period - 10'h001) ? msc_pkg::CNT_RESET : cnt_reg + 10'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cnt_reg <= msc_pkg::CNT_RESET;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

endmodule : msc_baud

// File: msc_controller.sv
// Multibuffer serial controller: 256-entry buffer memory walked in groups.
// Assumes synchronous inputs; software leaves configuration stable while busy.
`timescale 1ns/1ps
module msc_controller (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // Configuration
    input  wire logic        controller_mode,
    input  wire logic        clock_polarity,
    input  wire logic [7:0]  prescale,
    input  wire logic [7:0]  cs_to_clock_delay,
    input  wire logic [7:0]  clock_to_cs_delay,
    input  wire logic        chip_select_hold,
    // Group start
    input  wire logic [7:0]  group_first,
    input  wire logic [7:0]  group_last,
    input  wire logic        group_trigger,
    // Status
    output logic             busy,
    output logic             group_done,
    // Software memory port
    input  wire logic [7:0]  mem_addr,
    input  wire logic [1:0]  mem_field,
    input  wire logic        mem_write,
    input  wire logic [15:0] mem_wdata,
    output logic [15:0]      mem_rdata,
    // Serial pins
    output logic             serial_clock_pin_o,
    output logic             serial_clock_pin_oe,
    input  wire logic        serial_clock_pin_i,
    output logic             chip_select_n_o,
    output logic             chip_select_n_oe,
    output logic             controller_out_pin_o,
    output logic             controller_out_pin_oe,
    input  wire logic        controller_in_pin
);

    // Buffer memory, one array per field
    logic [15:0] tx_mem   [msc_pkg::RAM_DEPTH];
    logic [15:0] rx_mem   [msc_pkg::RAM_DEPTH];
    logic [15:0] ctl_mem  [msc_pkg::RAM_DEPTH];
    logic [15:0] stat_mem [msc_pkg::RAM_DEPTH];

    msc_pkg::msc_ctrl_type  r_reg;
    msc_pkg::msc_ctrl_type  r_next;

    logic                   edge_pulse;
    logic                   baud_load;
    logic [7:0]             load_idx;
    logic [4:0]             load_len;
    logic [15:0]            load_word;
    logic [9:0]             period;
    logic [9:0]             setup_cnt;
    logic [9:0]             release_cnt;
    logic                   lead_edge;
    logic [15:0]            stat_word;

    msc_baud u_baud (
        .ref_clk    (ref_clk),
        .rst_b      (rst_b),
        .run        (r_reg.state == msc_pkg::ST_SHIFT),
        .load_phase (baud_load),
        .prescale   (prescale),
        .edge_pulse (edge_pulse)
    );

    always_comb begin
        load_idx  = (r_reg.state == msc_pkg::ST_IDLE) ? group_first : r_reg.idx + 8'h01;
        load_len  = {1'b0, ctl_mem[load_idx][msc_pkg::CTL_LEN_LSB +: msc_pkg::CTL_LEN_W]} + 5'h01;
        if (load_len < msc_pkg::LEN_MIN) begin
            load_len = msc_pkg::LEN_MIN;
        end
        // Left-align so the first bit out is always bit 15
        load_word = tx_mem[load_idx] << (5'h10 - load_len);
        period    = msc_pkg::period_cycles(prescale);
        // Counters run down to zero, so each load is one less than the span
        setup_cnt = {2'h0, cs_to_clock_delay}
                  + (chip_select_hold ? msc_pkg::SETUP_HOLD_BASE : msc_pkg::SETUP_BASE)
                  - 10'h001;
        release_cnt = (period >> 1) + {2'h0, clock_to_cs_delay}
                    + msc_pkg::RELEASE_BASE - 10'h001;
        lead_edge = (r_reg.sclk == clock_polarity);
    end

    always_comb begin
        r_next       = r_reg;
        r_next.done  = 1'b0;
        r_next.drive = controller_mode;
        baud_load    = 1'b0;
        // Software read port, registered with the rest of the state
        case (mem_field)
            msc_pkg::FIELD_TX:  r_next.rdata = tx_mem[mem_addr];
            msc_pkg::FIELD_RX:  r_next.rdata = rx_mem[mem_addr];
            msc_pkg::FIELD_CTL: r_next.rdata = ctl_mem[mem_addr];
            default:            r_next.rdata = stat_mem[mem_addr];
        endcase
        case (r_reg.state)
            msc_pkg::ST_IDLE: begin
                r_next.sclk = clock_polarity;
                if (group_trigger && controller_mode) begin
                    r_next.idx       = group_first;
                    r_next.last_idx  = group_last;
                    r_next.sh_tx     = load_word;
                    r_next.mosi      = load_word[15];
                    r_next.bits_left = load_len;
                    r_next.cnt       = setup_cnt;
                    r_next.cs_n      = 1'b0;
                    r_next.busy      = 1'b1;
                    r_next.state     = msc_pkg::ST_SETUP;
                end
            end
            msc_pkg::ST_SETUP: begin
                if (r_reg.cnt == msc_pkg::CNT_RESET) begin
                    // First edge is a leading one: sample and start the baud phase
                    r_next.sclk  = ~r_reg.sclk;
                    r_next.sh_rx = {r_reg.sh_rx[14:0], controller_in_pin};
                    baud_load    = 1'b1;
                    r_next.state = msc_pkg::ST_SHIFT;
                end else begin
                    r_next.cnt = r_reg.cnt - 10'h001;
                end
            end
            msc_pkg::ST_SHIFT: begin
                if (edge_pulse) begin
                    r_next.sclk = ~r_reg.sclk;
                    if (lead_edge) begin
                        r_next.sh_rx = {r_reg.sh_rx[14:0], controller_in_pin};
                    end else if (r_reg.bits_left == 5'h01) begin
                        // Last edge: keep select across words when hold is on
                        if (chip_select_hold && (r_reg.idx != r_reg.last_idx)) begin
                            r_next.state = msc_pkg::ST_WRBK;
                        end else begin
                            r_next.cnt   = release_cnt;
                            r_next.state = msc_pkg::ST_HOLD;
                        end
                    end else begin
                        r_next.bits_left = r_reg.bits_left - 5'h01;
                        r_next.sh_tx     = {r_reg.sh_tx[14:0], 1'b0};
                        r_next.mosi      = r_reg.sh_tx[14];
                    end
                end
            end
            msc_pkg::ST_HOLD: begin
                if (r_reg.cnt == msc_pkg::CNT_RESET) begin
                    r_next.cs_n  = 1'b1;
                    r_next.state = msc_pkg::ST_WRBK;
                end else begin
                    r_next.cnt = r_reg.cnt - 10'h001;
                end
            end
            msc_pkg::ST_WRBK: begin
                r_next.sh_rx = msc_pkg::WORD_RESET;
                if (r_reg.idx == r_reg.last_idx) begin
                    r_next.busy  = 1'b0;
                    r_next.done  = 1'b1;
                    r_next.state = msc_pkg::ST_IDLE;
                end else begin
                    r_next.idx       = load_idx;
                    r_next.sh_tx     = load_word;
                    r_next.mosi      = load_word[15];
                    r_next.bits_left = load_len;
                    r_next.cnt       = setup_cnt;
                    r_next.cs_n      = 1'b0;
                    r_next.state     = msc_pkg::ST_SETUP;
                end
            end
            default: begin
                r_next.state = msc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            r_reg.state     <= msc_pkg::ST_IDLE;
            r_reg.idx       <= msc_pkg::IDX_RESET;
            r_reg.last_idx  <= msc_pkg::IDX_RESET;
            r_reg.cnt       <= msc_pkg::CNT_RESET;
            r_reg.bits_left <= msc_pkg::BITS_RESET;
            r_reg.sh_tx     <= msc_pkg::WORD_RESET;
            r_reg.sh_rx     <= msc_pkg::WORD_RESET;
            r_reg.sclk      <= 1'b0;
            r_reg.cs_n      <= 1'b1;
            r_reg.mosi      <= 1'b0;
            r_reg.drive     <= 1'b0;
            r_reg.busy      <= 1'b0;
            r_reg.done      <= 1'b0;
            r_reg.rdata     <= msc_pkg::WORD_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // Completion status; overrun marks an entry finished twice without a clear
    always_comb begin
        stat_word = msc_pkg::WORD_RESET;
        stat_word[msc_pkg::STAT_DONE_BIT]    = 1'b1;
        stat_word[msc_pkg::STAT_OVERRUN_BIT] = stat_mem[r_reg.idx][msc_pkg::STAT_DONE_BIT];
    end

    // Memory writes: the engine's write-back wins over software on the same entry
    always_ff @(posedge ref_clk) begin
        if (mem_write) begin
            case (mem_field)
                msc_pkg::FIELD_TX:   tx_mem[mem_addr]   <= mem_wdata;
                msc_pkg::FIELD_RX:   rx_mem[mem_addr]   <= mem_wdata;
                msc_pkg::FIELD_CTL:  ctl_mem[mem_addr]  <= mem_wdata;
                msc_pkg::FIELD_STAT: stat_mem[mem_addr] <= mem_wdata;
                default: begin
                end
            endcase
        end
        if (r_reg.state == msc_pkg::ST_WRBK) begin
            rx_mem[r_reg.idx]   <= r_reg.sh_rx;
            stat_mem[r_reg.idx] <= stat_word;
        end
    end

    // Outputs straight from flip-flops
    always_comb begin
        busy                  = r_reg.busy;
        group_done            = r_reg.done;
        mem_rdata             = r_reg.rdata;
        serial_clock_pin_o    = r_reg.sclk;
        serial_clock_pin_oe   = r_reg.drive;
        chip_select_n_o       = r_reg.cs_n;
        chip_select_n_oe      = r_reg.drive;
        controller_out_pin_o  = r_reg.mosi;
        controller_out_pin_oe = r_reg.drive;
    end

    // Peripheral mode clock is accepted but this build only runs as controller
    logic unused_clock_in;
    assign unused_clock_in = serial_clock_pin_i;

endmodule : msc_controller

// File: msc_chk.sv
// Concurrent checks on the pins and handshakes of the multibuffer serial controller.
// Assumes one clock domain; attached to msc_controller by the bind at the foot.
`timescale 1ns/1ps
module msc_chk (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst_b,
    // Configuration and start
    input wire logic       controller_mode,
    input wire logic       clock_polarity,
    input wire logic [7:0] prescale,
    input wire logic [7:0] cs_to_clock_delay,
    input wire logic [7:0] clock_to_cs_delay,
    input wire logic       chip_select_hold,
    input wire logic       group_trigger,
    // Status and pins
    input wire logic       busy,
    input wire logic       group_done,
    input wire logic       serial_clock_pin_o,
    input wire logic       serial_clock_pin_oe,
    input wire logic       chip_select_n_o,
    input wire logic       chip_select_n_oe,
    input wire logic       controller_out_pin_oe
);
    logic [9:0] per;
    logic [9:0] gap_reg;
    logic [9:0] setup_reg;
    logic       armed_reg;

    assign per = (prescale == 8'h00) ? 10'h002 : {2'h0, prescale} + 10'h001;

    // Cycles since the last clock change and since chip select fell
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            gap_reg   <= 10'h000;
            setup_reg <= 10'h000;
            armed_reg <= 1'b0;
        end else begin
            gap_reg   <= $changed(serial_clock_pin_o) ? 10'h001 : gap_reg + 10'h001;
            setup_reg <= $fell(chip_select_n_o) ? 10'h001 : setup_reg + 10'h001;
            armed_reg <= $fell(chip_select_n_o) ? 1'b1 : ($changed(serial_clock_pin_o) ? 1'b0 : armed_reg);
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    start_busy_a: assert property (group_trigger && controller_mode && !busy && !group_done |=> busy && !chip_select_n_o)
        else $error("group start not taken");
    refuse_a: assert property (!controller_mode && !busy |=> !busy)
        else $error("start taken in peripheral mode");
    setup_delay_a: assert property (armed_reg && $changed(serial_clock_pin_o)
        |-> setup_reg == {2'h0, cs_to_clock_delay} + (chip_select_hold ? 10'h003 : 10'h002))
        else $error("chip select to clock delay wrong");
    release_hold_a: assert property ($rose(chip_select_n_o) && !chip_select_hold
        |-> gap_reg == (per >> 1) + {2'h0, clock_to_cs_delay} + 10'h001)
        else $error("clock to chip select release wrong");
    half_period_a: assert property ($changed(serial_clock_pin_o) && serial_clock_pin_o == clock_polarity
        && !chip_select_n_o |-> gap_reg == per - (per >> 1))
        else $error("serial clock half period wrong");
    idle_cs_a: assert property (!busy && chip_select_n_oe |-> chip_select_n_o)
        else $error("chip select active while idle");
    pin_enable_a: assert property ($past(rst_b) |->
        {serial_clock_pin_oe, chip_select_n_oe, controller_out_pin_oe} == {3{$past(controller_mode)}})
        else $error("pin enables do not follow mode");
    done_pulse_a: assert property (group_done |-> !busy ##1 !group_done)
        else $error("group done not a single pulse");
    busy_end_a: assert property ($fell(busy) |-> group_done)
        else $error("busy fell without group done");
endmodule : msc_chk

bind msc_controller msc_chk msc_chk_inst (
    .ref_clk, .rst_b, .controller_mode, .clock_polarity, .prescale, .cs_to_clock_delay, .clock_to_cs_delay,
    .chip_select_hold, .group_trigger, .busy, .group_done, .serial_clock_pin_o, .serial_clock_pin_oe,
    .chip_select_n_o, .chip_select_n_oe, .controller_out_pin_oe
);

// File: msc_periph_model.sv
// Model of the external serial peripheral: captures on leading edges, answers on trailing.
// Assumes the serial clock idles at clock_polarity and moves only inside frames.
`timescale 1ns/1ps
module msc_periph_model (
    // Clock
    input wire logic        ref_clk,
    // Serial pins
    input wire logic        serial_clock_pin,
    input wire logic        clock_polarity,
    input wire logic        chip_select_n,
    input wire logic        controller_out_pin,
    output logic            controller_in_pin,
    // Bench side
    input wire logic [15:0] reply,
    output logic [15:0]     captured
);
    logic [15:0] out_sh = 16'h0000;

    initial begin
        controller_in_pin = 1'b0;
        captured = 16'h0000;
    end
    // New frame: clear capture and show the first reply bit
    always @(negedge chip_select_n) begin
        captured = 16'h0000;
        out_sh = reply;
        controller_in_pin = reply[15];
    end
    always @(serial_clock_pin) begin
        if (chip_select_n == 1'b0 && serial_clock_pin !== clock_polarity) begin
            captured = {captured[14:0], controller_out_pin};
        end else if (chip_select_n == 1'b0) begin
            out_sh = {out_sh[14:0], out_sh[15]};
            controller_in_pin = out_sh[15];
        end
    end
    // Deselected line carries a pattern that changes every cycle
    always @(negedge ref_clk) begin
        if (chip_select_n) begin
            controller_in_pin = ~controller_in_pin;
        end
    end
endmodule : msc_periph_model

// File: msc_controller_tb_top.sv
// Self-checking bench: random single-entry transfers, a held group, field access, refusal.
// Assumes msc_pkg, msc_controller, msc_periph_model and msc_chk are compiled before it.
`timescale 1ns/1ps
module msc_controller_tb_top;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        controller_mode = 1'b1;
    logic        clock_polarity = 1'b0;
    logic        chip_select_hold = 1'b0;
    logic        group_trigger = 1'b0;
    logic        mem_write = 1'b0;
    logic [7:0]  prescale = 8'h00;
    logic [7:0]  cs_to_clock_delay = 8'h00;
    logic [7:0]  clock_to_cs_delay = 8'h00;
    logic [7:0]  group_first = 8'h00;
    logic [7:0]  group_last = 8'h00;
    logic [7:0]  mem_addr = 8'h00;
    logic [1:0]  mem_field = 2'h0;
    logic [15:0] mem_wdata = 16'h0000;
    logic [15:0] reply = 16'h0000;
    logic [15:0] mem_rdata, captured;
    logic        busy, group_done, controller_in_pin;
    logic        serial_clock_pin_o, serial_clock_pin_oe, chip_select_n_o, chip_select_n_oe;
    logic        controller_out_pin_o, controller_out_pin_oe;
    logic [31:0] seed = 32'h5648;
    int          failures = 0;
    int          n_compared = 0;

    always #5 ref_clk = ~ref_clk;

    msc_controller msc_controller_inst (
        .ref_clk, .rst_b, .controller_mode, .clock_polarity, .prescale, .cs_to_clock_delay,
        .clock_to_cs_delay, .chip_select_hold, .group_first, .group_last, .group_trigger, .busy,
        .group_done, .mem_addr, .mem_field, .mem_write, .mem_wdata, .mem_rdata, .serial_clock_pin_o,
        .serial_clock_pin_oe, .serial_clock_pin_i(1'b0), .chip_select_n_o, .chip_select_n_oe,
        .controller_out_pin_o, .controller_out_pin_oe, .controller_in_pin
    );
    msc_periph_model msc_periph_model_inst (
        .ref_clk, .serial_clock_pin(serial_clock_pin_o), .clock_polarity, .chip_select_n(chip_select_n_o),
        .controller_out_pin(controller_out_pin_o), .controller_in_pin, .reply, .captured
    );

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Word length from the control field: length minus one, never below two bits
    function automatic logic [4:0] exp_len(input logic [3:0] c);
        return (c == 4'h0) ? 5'h02 : {1'b0, c} + 5'h01;
    endfunction : exp_len

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One memory port cycle; read data is settled at the following falling edge
    task automatic mem(input logic [7:0] a, input logic [1:0] f, input logic w, input logic [15:0] d);
        @(negedge ref_clk);
        mem_addr = a;
        mem_field = f;
        mem_write = w;
        mem_wdata = d;
        @(negedge ref_clk);
        mem_write = 1'b0;
    endtask : mem

    task automatic run(input logic [7:0] f, input logic [7:0] l);
        int k;
        @(negedge ref_clk);
        group_first = f;
        group_last = l;
        group_trigger = 1'b1;
        @(negedge ref_clk);
        group_trigger = 1'b0;
        for (k = 0; k < 20000 && group_done !== 1'b1; k++) @(negedge ref_clk);
        chk("group_done", 16'h0001, {15'h0000, group_done});
    endtask : run

    task automatic test_done();
        if (failures == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    initial begin
        int          i;
        logic [31:0] r;
        logic [7:0]  idx;
        logic [3:0]  lc;
        logic [4:0]  len;
        logic [15:0] tx;
        repeat (6) @(negedge ref_clk);
        rst_b = 1'b1;
        // All four fields of the first and last entry
        for (i = 0; i < 8; i++) begin
            r = xs();
            mem(i[2] ? 8'hFF : 8'h00, i[1:0], 1'b1, r[15:0]);
            mem(i[2] ? 8'hFF : 8'h00, i[1:0], 1'b0, 16'h0000);
            chk("mem_rdata", r[15:0], mem_rdata);
        end
        // Single-entry transfers; first two take the extreme prescale and lengths, the second also the largest delays
        for (i = 0; i < 12; i++) begin
            r = xs();
            prescale = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : {5'h00, r[2:0]};
            cs_to_clock_delay = (i == 1) ? 8'hFF : {4'h0, r[6:3]};
            clock_to_cs_delay = (i == 1) ? 8'hFF : {4'h0, r[10:7]};
            clock_polarity = r[11];
            lc = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : r[15:12];
            len = exp_len(lc);
            idx = r[23:16];
            r = xs();
            tx = r[15:0];
            reply = r[31:16];
            mem(idx, msc_pkg::FIELD_TX, 1'b1, tx);
            mem(idx, msc_pkg::FIELD_CTL, 1'b1, {12'h000, lc});
            mem(idx, msc_pkg::FIELD_STAT, 1'b1, 16'h0000);
            run(idx, idx);
            chk("captured", tx & (16'hFFFF >> (5'h10 - len)), captured);
            mem(idx, msc_pkg::FIELD_RX, 1'b0, 16'h0000);
            chk("rx", reply >> (5'h10 - len), mem_rdata);
            mem(idx, msc_pkg::FIELD_STAT, 1'b0, 16'h0000);
            chk("status", 16'h0001, mem_rdata);
        end
        // Three-entry group at the top of memory with chip select held; second pass overruns
        chip_select_hold = 1'b1;
        prescale = 8'h03;
        for (i = 253; i < 256; i++) begin
            mem(i[7:0], msc_pkg::FIELD_CTL, 1'b1, 16'h0007);
            mem(i[7:0], msc_pkg::FIELD_STAT, 1'b1, 16'h0000);
        end
        for (int p = 1; p < 3; p++) begin
            run(8'hFD, 8'hFF);
            for (i = 253; i < 256; i++) begin
                mem(i[7:0], msc_pkg::FIELD_STAT, 1'b0, 16'h0000);
                chk("status", (p == 1) ? 16'h0001 : 16'h0003, mem_rdata);
            end
        end
        // Start in peripheral mode is refused and pins stay released
        chip_select_hold = 1'b0;
        controller_mode = 1'b0;
        @(negedge ref_clk);
        group_trigger = 1'b1;
        @(negedge ref_clk);
        group_trigger = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("busy", 16'h0000, {15'h0000, busy});
        chk("sclk_oe", 16'h0000, {15'h0000, serial_clock_pin_oe});
        test_done();
    end

    initial begin
        repeat (40000) @(posedge ref_clk);
        failures++;
        test_done();
    end
endmodule : msc_controller_tb_top
